// ==== rtl/cbps_defs.svh ====
// Register map, field positions, reset values and widths of the channel binding block.
`ifndef CBPS_DEFS_SVH
`define CBPS_DEFS_SVH
`define CBPS_ADDR_W 12
`define CBPS_DATA_W 8
`define CBPS_ADDR_BIND 12'h216
`define CBPS_ADDR_RDIV_HI 12'h217
`define CBPS_ADDR_RDIV_LO 12'h218
`define CBPS_ADDR_SYNC 12'h219
`define CBPS_ADDR_CTRL 12'h2f0
`define CBPS_ADDR_STAT 12'h2f1
`define CBPS_RST_BIND 8'h02
`define CBPS_RST_RDIV 16'h0000
`define CBPS_RST_SYNC 8'h02
`define CBPS_RST_CTRL 8'h00
`define CBPS_BIT_SEL_A 0
`define CBPS_BIT_SEL_B 1
`define CBPS_BIT_NEXT 0
`define CBPS_BIT_ILA 1
`define CBPS_BIT_LINK_EN 0
`define CBPS_BIT_CAL_EN 1
`define CBPS_BIT_PD_A 2
`define CBPS_BIT_PD_B 3
`define CBPS_SAMPLE_W 12
`define CBPS_FIFO_DEPTH 16
`endif

// ==== rtl/cbps_pkg.sv ====
// Types shared by the channel binding block.
package cbps_pkg;
   // Origin of the most recent oscillator phase initialisation.
   typedef enum logic [1:0] {
      CBPS_SRC_NONE = 2'b00,
      CBPS_SRC_LANE = 2'b01,
      CBPS_SRC_PULSE = 2'b10
   } cbps_init_src_t;
endpackage

// ==== rtl/cbps_stream_if.sv ====
// Valid/ready stream carrier between the binding logic and its sample FIFO.
`timescale 1ns/10ps
interface cbps_stream_if #(parameter int WIDTH = 24);
   logic valid; // Data word is offered.
   logic ready; // Data word may be taken.
   logic [WIDTH-1:0] data; // Payload.
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

// ==== rtl/cbps_fifo.sv ====
// Synchronous sample FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module cbps_fifo
   import cbps_pkg::*;
#(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
)
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Filling and draining sides.
   cbps_stream_if.sink push,
   cbps_stream_if.source pop,
   // Fill state.
   output logic full,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // Sample storage.
   logic [AW:0] wr_ptr_reg; // Write pointer with wrap bit.
   logic [AW:0] rd_ptr_reg; // Read pointer with wrap bit.
   logic do_push;
   logic do_pop;

   // Full when the pointers differ only in the wrap bit.
   assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign push.ready = !full;
   assign pop.valid = !empty;
   assign pop.data = mem[rd_ptr_reg[AW-1:0]];
   assign do_push = push.valid && !full;
   assign do_pop = pop.ready && !empty;

   // Storage is written without reset; only the pointers need a defined state.
   always_ff @(posedge core_clk)
   begin
      if (do_push)
      begin
         mem[wr_ptr_reg[AW-1:0]] <= push.data;
      end
   end

   // Write pointer.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         wr_ptr_reg <= '0;
      end
      else if (do_push)
      begin
         wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
   end

   // Read pointer.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rd_ptr_reg <= '0;
      end
      else if (do_pop)
      begin
         rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end

   // A full FIFO must refuse the offered word.
   property p_no_overfill;
      @(posedge core_clk) disable iff (reset)
      full && !do_pop |=> $stable(wr_ptr_reg);
   endproperty
   a_no_overfill: assert property (p_no_overfill) else $error("FIFO pointer moved while full.");
endmodule

// ==== rtl/cbps_top.sv ====
// Channel binding, channel power-down and oscillator phase initialisation control.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "cbps_defs.svh"

// Operation
// - Digital B from converter A or B.
// - Digital A from converter A or B.
// - Channel powers down with bound converter.
// - Sixteen-bit divisor cancels frequency word error.
// - One divisor shared by all presets.
// - Lane-align bit initialises phase at alignment start.
// - Zero-then-one arms init on next pulse.
// - Later pulses ignored until re-armed.
// - Armed devices initialise on first pulse.
module cbps_top
   import cbps_pkg::*;
#(
   parameter int SAMPLE_W = `CBPS_SAMPLE_W,
   parameter int FIFO_DEPTH = `CBPS_FIFO_DEPTH
)
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Register port.
   input wire logic [`CBPS_ADDR_W-1:0] reg_addr,
   input wire logic [`CBPS_DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [`CBPS_DATA_W-1:0] reg_rdata,
   // Converter sample streams, one word per channel per beat.
   input wire logic [SAMPLE_W-1:0] conv_a_sample,
   input wire logic [SAMPLE_W-1:0] conv_b_sample,
   input wire logic conv_valid,
   output logic conv_ready,
   // Routed digital channel stream.
   output logic [SAMPLE_W-1:0] dig_a_sample,
   output logic [SAMPLE_W-1:0] dig_b_sample,
   output logic dig_valid,
   input wire logic dig_ready,
   // Power-down and link control towards the channels.
   output logic dig_a_powerdown,
   output logic dig_b_powerdown,
   output logic link_a_powerdown,
   output logic link_b_powerdown,
   output logic link_enable,
   output logic cal_enable,
   // Oscillator control.
   output logic [15:0] rational_divisor,
   input wire logic lane_align_start,
   input wire logic sysref_pin,
   output logic phase_init,
   output cbps_init_src_t phase_init_src
);
   localparam int PAIR_W = 2 * SAMPLE_W;

   // Address compare, used by both the write decode and the read mux.
   function automatic logic addr_hit(input logic [`CBPS_ADDR_W-1:0] a,
                                     input logic [`CBPS_ADDR_W-1:0] ref_a);
      addr_hit = (a == ref_a);
   endfunction

   logic [7:0] channel_binding_reg; // Binding register, reserved bits kept as written.
   logic [15:0] rdiv_reg; // Shared rational divisor.
   logic [7:0] sync_ctrl_reg; // Phase initialisation control register.
   logic [7:0] ctrl_reg; // Link, calibration and converter power-down bits.
   logic next_zero_seen_reg; // A 0 has been written to the next-pulse bit.
   logic armed_reg; // Waiting for a pulse rising edge.
   logic sysref_meta_reg; // First synchroniser stage.
   logic sysref_sync_reg; // Second synchroniser stage.
   logic sysref_prev_reg; // Delayed copy for edge detection.
   logic sysref_rise; // Synchronised rising edge.
   logic lane_fire; // Lane-alignment initialisation condition.
   logic pulse_fire; // Pulse initialisation condition.
   logic arm_write; // Write of 1 after a 0 to the next-pulse bit.
   logic phase_init_reg;
   cbps_init_src_t init_src_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic pd_a_next;
   logic pd_b_next;
   logic pd_a_reg;
   logic pd_b_reg;
   logic fifo_full;
   logic fifo_empty;
   logic wr_bind;
   logic wr_sync;

   cbps_stream_if #(.WIDTH(PAIR_W)) push_if ();
   cbps_stream_if #(.WIDTH(PAIR_W)) pop_if ();

   assign wr_bind = reg_write && addr_hit(reg_addr, `CBPS_ADDR_BIND);
   assign wr_sync = reg_write && addr_hit(reg_addr, `CBPS_ADDR_SYNC);

   // Binding register. Changing it under a running link is the host's
   // responsibility: the block does not stall the stream to make it safe.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         channel_binding_reg <= `CBPS_RST_BIND;
      end
      else if (wr_bind)
      begin
         channel_binding_reg <= reg_wdata;
      end
   end

   // Rational divisor, high byte at the lower address.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rdiv_reg <= `CBPS_RST_RDIV;
      end
      else if (reg_write && addr_hit(reg_addr, `CBPS_ADDR_RDIV_HI))
      begin
         rdiv_reg[15:8] <= reg_wdata;
      end
      else if (reg_write && addr_hit(reg_addr, `CBPS_ADDR_RDIV_LO))
      begin
         rdiv_reg[7:0] <= reg_wdata;
      end
   end

   // One divisor output feeds every oscillator preset alike.
   assign rational_divisor = rdiv_reg;

   // Phase initialisation control register.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         sync_ctrl_reg <= `CBPS_RST_SYNC;
      end
      else if (wr_sync)
      begin
         sync_ctrl_reg <= reg_wdata;
      end
   end

   // Link, calibration and converter power-down control bits.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         ctrl_reg <= `CBPS_RST_CTRL;
      end
      else if (reg_write && addr_hit(reg_addr, `CBPS_ADDR_CTRL))
      begin
         ctrl_reg <= reg_wdata;
      end
   end

   assign link_enable = ctrl_reg[`CBPS_BIT_LINK_EN];
   assign cal_enable = ctrl_reg[`CBPS_BIT_CAL_EN];

   // Each digital channel follows the power state of the converter it is bound to.
   always_comb
   begin
      if (channel_binding_reg[`CBPS_BIT_SEL_A])
      begin
         pd_a_next = ctrl_reg[`CBPS_BIT_PD_B];
      end
      else
      begin
         pd_a_next = ctrl_reg[`CBPS_BIT_PD_A];
      end
      if (channel_binding_reg[`CBPS_BIT_SEL_B])
      begin
         pd_b_next = ctrl_reg[`CBPS_BIT_PD_B];
      end
      else
      begin
         pd_b_next = ctrl_reg[`CBPS_BIT_PD_A];
      end
   end

   // Power-down outputs are registered so that they never glitch on a rebind.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         pd_a_reg <= 1'b0;
         pd_b_reg <= 1'b0;
      end
      else
      begin
         pd_a_reg <= pd_a_next;
         pd_b_reg <= pd_b_next;
      end
   end

   assign dig_a_powerdown = pd_a_reg;
   assign dig_b_powerdown = pd_b_reg;
   assign link_a_powerdown = pd_a_reg;
   assign link_b_powerdown = pd_b_reg;

   // Sample routing into the FIFO; a powered-down channel carries zeros.
   always_comb
   begin
      push_if.valid = conv_valid;
      push_if.data[PAIR_W-1:SAMPLE_W] = '0;
      push_if.data[SAMPLE_W-1:0] = '0;
      if (!pd_a_reg)
      begin
         push_if.data[SAMPLE_W-1:0] = channel_binding_reg[`CBPS_BIT_SEL_A] ?
                                      conv_b_sample : conv_a_sample;
      end
      if (!pd_b_reg)
      begin
         push_if.data[PAIR_W-1:SAMPLE_W] = channel_binding_reg[`CBPS_BIT_SEL_B] ?
                                           conv_b_sample : conv_a_sample;
      end
   end

   // Back-pressure from the FIFO reaches the converter side directly.
   assign conv_ready = push_if.ready;

   cbps_fifo #(.WIDTH(PAIR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .reset(reset),
      .push(push_if),
      .pop(pop_if),
      .full(fifo_full),
      .empty(fifo_empty)
   );

   assign dig_valid = pop_if.valid;
   assign pop_if.ready = dig_ready;
   assign dig_a_sample = pop_if.data[SAMPLE_W-1:0];
   assign dig_b_sample = pop_if.data[PAIR_W-1:SAMPLE_W];

   // Pulse pin synchroniser; the first stage feeds only the second.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         sysref_meta_reg <= 1'b0;
         sysref_sync_reg <= 1'b0;
         sysref_prev_reg <= 1'b0;
      end
      else
      begin
         sysref_meta_reg <= sysref_pin;
         sysref_sync_reg <= sysref_meta_reg;
         sysref_prev_reg <= sysref_sync_reg;
      end
   end

   assign sysref_rise = sysref_sync_reg && !sysref_prev_reg;

   // Remember a 0 written to the next-pulse bit; a later 1 then arms.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         next_zero_seen_reg <= 1'b0;
      end
      else if (wr_sync)
      begin
         next_zero_seen_reg <= !reg_wdata[`CBPS_BIT_NEXT];
      end
   end

   assign arm_write = wr_sync && reg_wdata[`CBPS_BIT_NEXT] && next_zero_seen_reg;

   // Armed flag. A fresh arm in the same cycle as a firing edge wins, so the
   // new arming is not lost; the edge still initialises the phase.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         armed_reg <= 1'b0;
      end
      else if (arm_write)
      begin
         armed_reg <= 1'b1;
      end
      else if (sysref_rise)
      begin
         armed_reg <= 1'b0;
      end
   end

   assign lane_fire = sync_ctrl_reg[`CBPS_BIT_ILA] && lane_align_start;
   assign pulse_fire = armed_reg && sysref_rise;

   // Phase initialisation strobe; edges seen while unarmed do nothing.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         phase_init_reg <= 1'b0;
      end
      else
      begin
         phase_init_reg <= lane_fire || pulse_fire;
      end
   end

   // Source of the latest initialisation, kept for status reads.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         init_src_reg <= CBPS_SRC_NONE;
      end
      else if (pulse_fire)
      begin
         init_src_reg <= CBPS_SRC_PULSE;
      end
      else if (lane_fire)
      begin
         init_src_reg <= CBPS_SRC_LANE;
      end
   end

   assign phase_init = phase_init_reg;
   assign phase_init_src = init_src_reg;

   // Read mux; unmapped addresses read as zero.
   always_comb
   begin
      rdata_next = 8'h00;
      if (addr_hit(reg_addr, `CBPS_ADDR_BIND))
      begin
         rdata_next = channel_binding_reg;
      end
      else if (addr_hit(reg_addr, `CBPS_ADDR_RDIV_HI))
      begin
         rdata_next = rdiv_reg[15:8];
      end
      else if (addr_hit(reg_addr, `CBPS_ADDR_RDIV_LO))
      begin
         rdata_next = rdiv_reg[7:0];
      end
      else if (addr_hit(reg_addr, `CBPS_ADDR_SYNC))
      begin
         rdata_next = sync_ctrl_reg;
      end
      else if (addr_hit(reg_addr, `CBPS_ADDR_CTRL))
      begin
         rdata_next = ctrl_reg;
      end
      else if (addr_hit(reg_addr, `CBPS_ADDR_STAT))
      begin
         rdata_next = {1'b0, fifo_empty, fifo_full, init_src_reg, pd_b_reg, pd_a_reg,
                       armed_reg};
      end
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rdata_reg <= 8'h00;
      end
      else
      begin
         rdata_reg <= reg_read ? rdata_next : 8'h00;
      end
   end

   assign reg_rdata = rdata_reg;

   property p_route_b;
      @(posedge core_clk) disable iff (reset)
      !pd_b_reg |-> push_if.data[PAIR_W-1:SAMPLE_W] ==
         (channel_binding_reg[`CBPS_BIT_SEL_B] ? conv_b_sample : conv_a_sample);
   endproperty
   a_route_b: assert property (p_route_b) else $error("Channel B routing wrong.");

   property p_route_a;
      @(posedge core_clk) disable iff (reset)
      !pd_a_reg |-> push_if.data[SAMPLE_W-1:0] ==
         (channel_binding_reg[`CBPS_BIT_SEL_A] ? conv_b_sample : conv_a_sample);
   endproperty
   a_route_a: assert property (p_route_a) else $error("Channel A routing wrong.");

   property p_pd_follow;
      @(posedge core_clk) disable iff (reset)
      (!channel_binding_reg[`CBPS_BIT_SEL_A] && ctrl_reg[`CBPS_BIT_PD_A])
         |=> dig_a_powerdown && link_a_powerdown;
   endproperty
   a_pd_follow: assert property (p_pd_follow) else $error("Channel A not powered down.");

   property p_rdiv_hi;
      @(posedge core_clk) disable iff (reset)
      reg_write && reg_addr == `CBPS_ADDR_RDIV_HI |=> rational_divisor[15:8] == $past(reg_wdata)
         && $stable(rational_divisor[7:0]);
   endproperty
   a_rdiv_hi: assert property (p_rdiv_hi) else $error("Divisor high byte not taken.");

   property p_rdiv_lo;
      @(posedge core_clk) disable iff (reset)
      reg_write && reg_addr == `CBPS_ADDR_RDIV_LO |=> rational_divisor[7:0] == $past(reg_wdata)
         && $stable(rational_divisor[15:8]);
   endproperty
   a_rdiv_lo: assert property (p_rdiv_lo) else $error("Divisor low byte not taken.");

   property p_lane_init;
      @(posedge core_clk) disable iff (reset)
      sync_ctrl_reg[`CBPS_BIT_ILA] && lane_align_start |=> phase_init;
   endproperty
   a_lane_init: assert property (p_lane_init) else $error("Lane start missed.");

   property p_pulse_init;
      @(posedge core_clk) disable iff (reset)
      armed_reg && sysref_rise && !arm_write |=> phase_init && !armed_reg;
   endproperty
   a_pulse_init: assert property (p_pulse_init) else $error("Armed pulse missed.");

   property p_ignore;
      @(posedge core_clk) disable iff (reset)
      !armed_reg && !(sync_ctrl_reg[`CBPS_BIT_ILA] && lane_align_start) |=> !phase_init;
   endproperty
   a_ignore: assert property (p_ignore) else $error("Unarmed edge initialised phase.");

   property p_arm_first;
      @(posedge core_clk) disable iff (reset)
      arm_write ##1 (!sysref_rise && !lane_align_start) [*3] ##1 sysref_rise |=> phase_init;
   endproperty
   a_arm_first: assert property (p_arm_first) else $error("First pulse after arm missed.");
endmodule

// ==== sim/cbps_sysref_model.sv ====
// Behavioural pulse source that stands on the far side of the phase initialisation logic.
`timescale 1ns/10ps
module cbps_sysref_model
(
   // Request and speed choice from the bench.
   input wire logic fire_req,
   input wire logic slow,
   // Pulse line towards the device.
   output logic sysref_pin
);
   // The line rests low between requests, so no edge reaches the device unasked.
   // Each request makes exactly one rising edge, 13 ns after the device clock edge that raised the request.
   // The slow form holds the pulse for several cycles, so a level is not taken for an edge.
   // One process owns the line, so it has a single driver.
   initial
   begin
      sysref_pin = 1'b0;
      forever
      begin
         @(posedge fire_req);
         #13;
         sysref_pin = 1'b1;
         #(slow ? 300 : 90);
         sysref_pin = 1'b0;
      end
   end
endmodule

// ==== sim/cbps_tb_top.sv ====
// Self-checking bench for the channel binding and phase initialisation block.
`timescale 1ns/10ps
`include "cbps_defs.svh"
module cbps_tb_top
   import cbps_pkg::*;
();
   // Clock, reset and register port.
   logic core_clk, reset, reg_write, reg_read;
   logic [`CBPS_ADDR_W-1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   // Sample streams on both sides of the buffer.
   logic [11:0] conv_a_sample, conv_b_sample, dig_a_sample, dig_b_sample;
   logic conv_valid, conv_ready, dig_valid, dig_ready;
   // Channel controls and oscillator signals.
   logic dig_a_powerdown, dig_b_powerdown, link_a_powerdown, link_b_powerdown;
   logic link_enable, cal_enable, lane_align_start, sysref_pin, phase_init;
   logic [15:0] rational_divisor;
   cbps_init_src_t phase_init_src;
   // Pulse source requests.
   logic fire_req, slow;
   // Verdict counters.
   int error_cnt = 0;
   int tests_run = 0;

   cbps_top #(.SAMPLE_W(12), .FIFO_DEPTH(16)) DUT (.core_clk(core_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .conv_a_sample(conv_a_sample),
      .conv_b_sample(conv_b_sample), .conv_valid(conv_valid), .conv_ready(conv_ready),
      .dig_a_sample(dig_a_sample), .dig_b_sample(dig_b_sample), .dig_valid(dig_valid),
      .dig_ready(dig_ready), .dig_a_powerdown(dig_a_powerdown),
      .dig_b_powerdown(dig_b_powerdown), .link_a_powerdown(link_a_powerdown),
      .link_b_powerdown(link_b_powerdown), .link_enable(link_enable),
      .cal_enable(cal_enable), .rational_divisor(rational_divisor),
      .lane_align_start(lane_align_start), .sysref_pin(sysref_pin),
      .phase_init(phase_init), .phase_init_src(phase_init_src));

   cbps_sysref_model SREF (.fire_req(fire_req), .slow(slow), .sysref_pin(sysref_pin));

   // Free-running 25 MHz clock.
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // Prints the verdict and stops the run.
   task automatic end_sim();
      if (error_cnt == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Compares with case equality, so an unknown never passes.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   // One-cycle register write.
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask

   // One-cycle read; the data stand only in the following cycle.
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      @(posedge core_clk);
      chk(reg_rdata, exp);
   endtask

   // Offers one beat and holds it until the buffer takes it.
   task automatic push(input logic [11:0] a, input logic [11:0] b);
      int n = 0;
      @(posedge core_clk);
      conv_a_sample <= a;
      conv_b_sample <= b;
      conv_valid <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (conv_ready !== 1'b1 && n < 50);
      conv_valid <= 1'b0;
   endtask

   // Waits for the head word, checks it, then takes it.
   task automatic pop(input logic [11:0] a, input logic [11:0] b);
      int n = 0;
      @(posedge core_clk);
      while (dig_valid !== 1'b1 && n < 50)
      begin
         @(posedge core_clk);
         n++;
      end
      chk(dig_a_sample, a);
      chk(dig_b_sample, b);
      dig_ready <= 1'b1;
      @(posedge core_clk);
      dig_ready <= 1'b0;
   endtask

   // Counts initialisation pulses over a fixed span.
   task automatic count_init(input int n, input int exp);
      int cnt = 0;
      repeat (n)
      begin
         @(posedge core_clk);
         if (phase_init === 1'b1)
            cnt++;
      end
      chk(16'(cnt), 16'(exp));
   endtask

   // Asks the pulse source for one pulse.
   task automatic fire(input logic s);
      @(posedge core_clk);
      slow <= s;
      fire_req <= 1'b1;
      @(posedge core_clk);
      fire_req <= 1'b0;
   endtask

   // Reset values, an unmapped address and the divisor bytes.
   task automatic t_regs();
      rd(`CBPS_ADDR_BIND, 8'h02);
      rd(`CBPS_ADDR_SYNC, 8'h02);
      rd(`CBPS_ADDR_RDIV_HI, 8'h00);
      rd(12'h3a5, 8'h00);
      chk(rational_divisor, 16'h0000);
      wr(`CBPS_ADDR_RDIV_HI, 8'ha5);
      wr(`CBPS_ADDR_RDIV_LO, 8'h3c);
      wr(`CBPS_ADDR_CTRL, 8'h02);
      // The last write lands at the edge the write task returns on; wait one more.
      @(posedge core_clk);
      chk(rational_divisor, 16'ha53c);
      chk(cal_enable, 1'b1);
      chk(link_enable, 1'b0);
      rd(`CBPS_ADDR_RDIV_LO, 8'h3c);
   endtask

   // Every binding code, each with a distinct word on the two converters.
   task automatic t_binding();
      logic [11:0] av, bv;
      for (int b = 0; b < 4; b++)
      begin
         av = 12'h1a0 + 12'(b);
         bv = 12'h2b0 + 12'(b);
         wr(`CBPS_ADDR_CTRL, 8'h00);
         wr(`CBPS_ADDR_BIND, 8'(b));
         push(av, bv);
         pop(b[0] ? bv : av, b[1] ? bv : av);
      end
      wr(`CBPS_ADDR_BIND, `CBPS_RST_BIND);
   endtask

   // Channel and link power-down follow whichever converter is bound.
   task automatic t_powerdown();
      logic [7:0] pd;
      for (int b = 0; b < 4; b++)
         for (int k = 0; k < 2; k++)
         begin
            pd = k ? 8'h08 : 8'h04;
            wr(`CBPS_ADDR_CTRL, 8'h00);
            wr(`CBPS_ADDR_BIND, 8'(b));
            wr(`CBPS_ADDR_CTRL, pd);
            repeat (2) @(posedge core_clk);
            chk(dig_a_powerdown, b[0] ? pd[3] : pd[2]);
            chk(link_a_powerdown, b[0] ? pd[3] : pd[2]);
            chk(dig_b_powerdown, b[1] ? pd[3] : pd[2]);
            chk(link_b_powerdown, b[1] ? pd[3] : pd[2]);
         end
      wr(`CBPS_ADDR_CTRL, 8'h00);
      wr(`CBPS_ADDR_BIND, `CBPS_RST_BIND);
      wr(`CBPS_ADDR_CTRL, 8'h04);
      push(12'h5a5, 12'h3c3);
      pop(12'h000, 12'h3c3);
      wr(`CBPS_ADDR_CTRL, 8'h00);
   endtask

   // Fills the buffer with the sink stalled, offers a refused beat, then drains in order.
   task automatic t_fifo();
      for (int i = 0; i < 16; i++)
         push(12'h300 + 12'(i), 12'h0c0 + 12'(i));
      @(posedge core_clk);
      chk(conv_ready, 1'b0);
      rd(`CBPS_ADDR_STAT, 8'h20);
      conv_a_sample <= 12'hfff;
      conv_valid <= 1'b1;
      repeat (3) @(posedge core_clk);
      conv_valid <= 1'b0;
      for (int i = 0; i < 16; i++)
         pop(12'h300 + 12'(i), 12'h0c0 + 12'(i));
      @(posedge core_clk);
      chk(dig_valid, 1'b0);
   endtask

   // Lane-alignment start initialises phase only while its enable bit is set.
   task automatic t_lane();
      wr(`CBPS_ADDR_SYNC, 8'h02);
      @(posedge core_clk);
      lane_align_start <= 1'b1;
      @(posedge core_clk);
      lane_align_start <= 1'b0;
      @(posedge core_clk);
      chk(phase_init, 1'b1);
      chk(phase_init_src, CBPS_SRC_LANE);
      wr(`CBPS_ADDR_SYNC, 8'h00);
      @(posedge core_clk);
      lane_align_start <= 1'b1;
      @(posedge core_clk);
      lane_align_start <= 1'b0;
      count_init(6, 0);
   endtask

   // Arming, the first pulse, ignored later pulses and re-arming.
   task automatic t_pulse();
      wr(`CBPS_ADDR_CTRL, 8'h01);
      fire(1'b0);
      count_init(12, 0);
      chk(link_enable, 1'b1);
      wr(`CBPS_ADDR_SYNC, 8'h00);
      wr(`CBPS_ADDR_SYNC, 8'h01);
      fire(1'b0);
      count_init(12, 1);
      chk(phase_init_src, CBPS_SRC_PULSE);
      fire(1'b1);
      count_init(16, 0);
      wr(`CBPS_ADDR_SYNC, 8'h01);
      fire(1'b0);
      count_init(12, 0);
      wr(`CBPS_ADDR_SYNC, 8'h00);
      wr(`CBPS_ADDR_SYNC, 8'h01);
      fire(1'b1);
      count_init(16, 1);
   endtask

   // Main sequence: reset for five cycles, then every scenario in turn.
   initial
   begin
      reset = 1'b1;
      reg_addr = '0;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      conv_a_sample = 12'h000;
      conv_b_sample = 12'h000;
      conv_valid = 1'b0;
      dig_ready = 1'b0;
      lane_align_start = 1'b0;
      fire_req = 1'b0;
      slow = 1'b0;
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      t_regs();
      t_binding();
      t_powerdown();
      t_fifo();
      t_lane();
      t_pulse();
      end_sim();
   end

   // Watchdog: the scenarios need a few hundred cycles, so this span means a hang.
   initial
   begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      end_sim();
   end
endmodule
